// [src/accel_port_pkg.sv]
// Shared constants, field positions and carrier types of the accelerometer serial port.
package accel_port_pkg;

    // ------------------------------------------------------------------
    // Result formats
    // ------------------------------------------------------------------
    localparam int ACC_BITS        = 12;
    localparam int TEMP_BITS       = 10;
    localparam int FRAME_CLOCKS    = 16;
    localparam int CTRL_BITS       = 8;
    localparam logic [11:0] ACC_MIDPOINT    = 12'h800;
    localparam logic [11:0] ACC_PLUS_5G     = 12'hd00;
    localparam logic [11:0] ACC_MINUS_5G    = 12'h300;
    localparam logic [11:0] ACC_SHUTDOWN    = 12'h000;
    localparam logic [11:0] SELFTEST_DELTA  = 12'h0cd;

    // ------------------------------------------------------------------
    // Control word field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_AXIS_POS      = 3;
    localparam int CTRL_POWER_POS     = 0;
    localparam logic [7:0] CTRL_RESET = 8'h04;
    localparam logic [7:0] TCTRL_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Frame timing in serial clock edges
    // ------------------------------------------------------------------
    localparam logic [3:0] CAPTURE_EDGE_IDX = 4'h1;
    localparam logic [3:0] CTRL_LAST_IDX    = 4'h7;
    localparam logic [3:0] LAST_EDGE_IDX    = 4'hf;
    localparam logic [3:0] TEMP_LAST_FALL   = 4'ha;
    localparam logic [3:0] ACC_LEAD_ZEROS   = 4'h4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PORT_IDLE  = 2'b00,
        PORT_ACCEL = 2'b01,
        PORT_TEMP  = 2'b10
    } port_state_e;

    typedef struct packed {
        logic [11:0] x_code;
        logic [11:0] y_code;
    } sample_s;

    localparam int SAMPLE_W = $bits(sample_s);

endpackage

// [src/pin_sync.sv]
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE  = '1
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pins,
    output logic      [WIDTH-1:0] synced
);

    logic [WIDTH-1:0] stage1;

    // The first stage feeds only the second stage to contain metastability.
    // Reset loads each pin's idle level, so no false edge follows reset.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            stage1 <= IDLE;
            synced <= IDLE;
        end
        else
        begin
            stage1 <= pins;
            synced <= stage1;
        end
    end

endmodule
`default_nettype wire

// [src/sample_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("sample_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;
    logic [AW:0]      next_count;

    // Handshakes and the occupancy after this cycle.
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // Storage writes.
    always_ff @(posedge clock)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // Pointers, count and a registered ready so the source sees a clean level.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            in_ready <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            count    <= next_count;
            in_ready <= (next_count != DEPTH[AW:0]);
        end
    end

endmodule
`default_nettype wire

// [src/accel_serial_port.sv]
// Serial port of a dual-axis accelerometer with a temperature sensor read path.
//
// Notes on behaviour
// - Accelerometer results are 12-bit offset binary, zero g at the midpoint code.
// - Scale is 256 codes per g; plus and minus five g read 0xd00 and 0x300.
// - Accelerometer select falling edge starts a conversion and a framed result transfer.
// - The sample is taken on the second rising serial clock after select falls.
// - A conversion takes 16 serial clocks; the master supplies all of them.
// - Accelerometer select rising releases the data-out driver.
// - Select held low after 16 clocks starts the next conversion directly.
// - Control bit 3 selects the axis: 0 is x, 1 is y.
// - Control bit 0 set to 1 shuts down, 0 runs normally.
// - Control register contents are kept throughout shutdown.
// - An axis change or entering shutdown takes effect as soon as the control register updates.
// - Leaving shutdown happens on the 16th rising serial clock of that frame.
// - Temperature frame sends a leading zero then ten result bits in 16 clocks.
// - After the last temperature bit data-out holds until select rises, then floats.
// - Data-in enters the temperature control register on the first eight rising clocks of the frame.
// - Data-out changes on falling serial clock edges.
// - Accelerometer control bits enter on rising serial clock edges.
// - Temperature result is 10-bit twos complement, 0.25 degree per code.
`timescale 1ns/1ps
`default_nettype none
module accel_serial_port #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    input  wire logic                        acc_frame_select_n,
    input  wire logic                        temp_frame_select_n,
    input  wire logic                        sclk,
    input  wire logic                        din,
    output logic                             dout,
    output logic                             dout_oe,
    input  wire logic                        selftest_in,
    input  wire logic                        sample_valid,
    output logic                             sample_ready,
    input  wire accel_port_pkg::sample_s     sample_data,
    input  wire logic [9:0]                  temp_code,
    output logic                             power_down,
    output logic                             axis_y,
    output logic [7:0]                       temp_control
);

    initial
    begin
        if (FIFO_DEPTH < 2)
            $error("accel_serial_port: FIFO_DEPTH must be at least 2");
    end

    // ------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------
    logic [4:0] pins_sync;
    logic       cs_n_s;
    logic       tcs_n_s;
    logic       sclk_s;
    logic       din_s;
    logic       st_s;
    logic       cs_n_d;
    logic       tcs_n_d;
    logic       sclk_d;
    logic       cs_fall;
    logic       cs_rise;
    logic       tcs_fall;
    logic       tcs_rise;
    logic       sclk_rise;
    logic       sclk_fall;

    pin_sync #(
        .WIDTH (5),
        .IDLE  (5'b00011)
    ) u_pin_sync (
        .clock  (clock),
        .rst_n  (rst_n),
        .pins   ({selftest_in, din, sclk, temp_frame_select_n, acc_frame_select_n}),
        .synced (pins_sync)
    );

    assign {st_s, din_s, sclk_s, tcs_n_s, cs_n_s} = pins_sync;

    // Previous values of the synchronised pins for edge detection.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cs_n_d  <= 1'b1;
            tcs_n_d <= 1'b1;
            sclk_d  <= 1'b0;
        end
        else
        begin
            cs_n_d  <= cs_n_s;
            tcs_n_d <= tcs_n_s;
            sclk_d  <= sclk_s;
        end
    end

    // Edges seen on the synchronised copies only.
    assign cs_fall   = cs_n_d && !cs_n_s;
    assign cs_rise   = !cs_n_d && cs_n_s;
    assign tcs_fall  = tcs_n_d && !tcs_n_s;
    assign tcs_rise  = !tcs_n_d && tcs_n_s;
    assign sclk_rise = !sclk_d && sclk_s;
    assign sclk_fall = sclk_d && !sclk_s;

    // ------------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------------
    accel_port_pkg::port_state_e state;
    accel_port_pkg::port_state_e next_state;

    // Accelerometer select wins if a misbehaving master lowers both at once.
    // select exclusivity
    always_comb
    begin
        next_state = state;
        unique case (state)
            accel_port_pkg::PORT_IDLE:
            begin
                if (cs_fall)
                    next_state = accel_port_pkg::PORT_ACCEL;
                else if (tcs_fall)
                    next_state = accel_port_pkg::PORT_TEMP;
            end
            accel_port_pkg::PORT_ACCEL:
            begin
                if (cs_rise)
                    next_state = accel_port_pkg::PORT_IDLE;
            end
            accel_port_pkg::PORT_TEMP:
            begin
                if (tcs_rise)
                    next_state = accel_port_pkg::PORT_IDLE;
            end
            default:
                next_state = accel_port_pkg::PORT_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            state <= accel_port_pkg::PORT_IDLE;
        else
            state <= next_state;
    end

    logic in_acc;
    logic in_temp;
    assign in_acc  = (state == accel_port_pkg::PORT_ACCEL) && !cs_rise;
    assign in_temp = (state == accel_port_pkg::PORT_TEMP) && !tcs_rise;

    // ------------------------------------------------------------------
    // Serial clock counters
    // ------------------------------------------------------------------
    logic [3:0] rise_cnt;
    logic [3:0] fall_cnt;

    // Both counters wrap at 16, so a held select rolls into the next frame.
    // sixteen-clock conversion
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rise_cnt <= 4'h0;
            fall_cnt <= 4'h0;
        end
        else if ((cs_fall || tcs_fall) && state == accel_port_pkg::PORT_IDLE)
        begin
            rise_cnt <= 4'h0;
            fall_cnt <= 4'h0;
        end
        else if (in_acc || in_temp)
        begin
            if (sclk_rise)
                rise_cnt <= rise_cnt + 4'h1;
            if (sclk_fall)
                fall_cnt <= fall_cnt + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Sample buffer from the sensing front end
    // ------------------------------------------------------------------
    logic                    fifo_valid;
    logic                    fifo_pop;
    accel_port_pkg::sample_s fifo_data;
    logic                    capture;

    sample_fifo #(
        .WIDTH (accel_port_pkg::SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_sample_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   (sample_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    assign capture  = in_acc && sclk_rise && (rise_cnt == accel_port_pkg::CAPTURE_EDGE_IDX);
    assign fifo_pop = capture && !power_down;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [7:0] ctrl_shift;
    logic [7:0] control;
    logic [7:0] new_word;
    logic       wake_pending;

    assign new_word = {ctrl_shift[6:0], din_s};

    // Control bits shift in MSB first on rising edges of the first eight clocks.
    // rising edge capture
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            ctrl_shift <= 8'h00;
        else if (in_acc && sclk_rise && rise_cnt <= accel_port_pkg::CTRL_LAST_IDX)
            ctrl_shift <= new_word;
    end

    // The word lands after the eighth clock; power-down applies at once, waking
    // waits for the sixteenth clock. The reserved bits are stored but unused.
    // reserved bits ignored
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            control      <= accel_port_pkg::CTRL_RESET;
            power_down   <= 1'b0;
            axis_y       <= 1'b0;
            wake_pending <= 1'b0;
        end
        else if (in_acc && sclk_rise)
        begin
            if (rise_cnt == accel_port_pkg::CTRL_LAST_IDX)
            begin
                control <= new_word;
                axis_y  <= new_word[accel_port_pkg::CTRL_AXIS_POS];
                if (new_word[accel_port_pkg::CTRL_POWER_POS])
                begin
                    power_down   <= 1'b1;
                    wake_pending <= 1'b0;
                end
                else
                    wake_pending <= power_down;
            end
            else if (rise_cnt == accel_port_pkg::LAST_EDGE_IDX && wake_pending)
            begin
                power_down   <= 1'b0;
                wake_pending <= 1'b0;
            end
        end
        else if (cs_rise)
            wake_pending <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Accelerometer result
    // ------------------------------------------------------------------
    logic [11:0] last_x;
    logic [11:0] last_y;
    logic [11:0] acc_result;
    logic [11:0] raw_code;

    // An empty buffer repeats the previous sample rather than stalling the frame.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            last_x <= accel_port_pkg::ACC_MIDPOINT;
            last_y <= accel_port_pkg::ACC_MIDPOINT;
        end
        else if (fifo_pop && fifo_valid)
        begin
            last_x <= fifo_data.x_code;
            last_y <= fifo_data.y_code;
        end
    end

    // Front-end codes are already offset binary at 256 codes per g; self-test
    // shifts them by a fixed step. A shut-down part reports zero.
    // offset binary result
    always_comb
    begin
        if (fifo_valid)
            raw_code = axis_y ? fifo_data.y_code : fifo_data.x_code;
        else
            raw_code = axis_y ? last_y : last_x;
        if (st_s)
            raw_code = raw_code + accel_port_pkg::SELFTEST_DELTA;
    end

    // Result register, loaded on the capture edge.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            acc_result <= accel_port_pkg::ACC_MIDPOINT;
        else if (capture)
            acc_result <= power_down ? accel_port_pkg::ACC_SHUTDOWN : raw_code;
    end

    // ------------------------------------------------------------------
    // Temperature path
    // ------------------------------------------------------------------
    logic [9:0] temp_latch;
    logic [7:0] temp_shift;

    // The reading is frozen at select so the frame stays self-consistent.
    // twos complement code
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            temp_latch <= 10'h000;
        else if (tcs_fall && state == accel_port_pkg::PORT_IDLE && !cs_fall)
            temp_latch <= temp_code;
    end

    // Data-in is taken during the read; only the first eight bits are kept.
    // concurrent control write
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            temp_shift   <= accel_port_pkg::TCTRL_RESET;
            temp_control <= accel_port_pkg::TCTRL_RESET;
        end
        else if (in_temp && sclk_rise && rise_cnt <= accel_port_pkg::CTRL_LAST_IDX)
        begin
            temp_shift <= {temp_shift[6:0], din_s};
            if (rise_cnt == accel_port_pkg::CTRL_LAST_IDX)
                temp_control <= {temp_shift[6:0], din_s};
        end
    end

    // ------------------------------------------------------------------
    // Data-out driver
    // ------------------------------------------------------------------
    logic [3:0] next_fall;
    logic [3:0] acc_idx;
    logic [3:0] temp_idx;
    assign next_fall = fall_cnt + 4'h1;
    assign acc_idx   = accel_port_pkg::LAST_EDGE_IDX - next_fall;
    assign temp_idx  = accel_port_pkg::TEMP_LAST_FALL - next_fall;

    // A frame opens with a zero bit; later bits move on falling edges only.
    // frame start
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            dout    <= 1'b0;
            dout_oe <= 1'b0;
        end
        else if (cs_rise || (tcs_rise && state == accel_port_pkg::PORT_TEMP))
        begin
            dout    <= 1'b0;
            dout_oe <= 1'b0;
        end
        else if ((cs_fall || tcs_fall) && state == accel_port_pkg::PORT_IDLE)
        begin
            dout    <= 1'b0;
            dout_oe <= 1'b1;
        end
        else if (in_acc && sclk_fall)
        begin
            if (next_fall < accel_port_pkg::ACC_LEAD_ZEROS)
                dout <= 1'b0;
            else
                dout <= acc_result[acc_idx];
        end
        else if (in_temp && sclk_fall && fall_cnt < accel_port_pkg::TEMP_LAST_FALL)
            dout <= temp_latch[temp_idx];
    end

endmodule
`default_nettype wire

// [tb/port_sva.sv]
// Pin-level timing checks for the accelerometer serial port.
`timescale 1ns/1ps
`default_nettype none
module port_sva (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       acc_frame_select_n,
    input wire logic       temp_frame_select_n,
    input wire logic       sclk,
    input wire logic       dout,
    input wire logic       dout_oe,
    input wire logic       power_down,
    input wire logic       axis_y,
    input wire logic [7:0] temp_control
);
    // ----
    // Link timing, pins seen three clocks late
    // ----
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_ACC_OPEN: assert property (
        $fell(acc_frame_select_n) && temp_frame_select_n && !dout_oe |-> ##3 dout_oe && !dout)
        else $error("accel frame did not open");
    AST_ACC_RELEASE: assert property (
        $rose(acc_frame_select_n) && temp_frame_select_n |-> ##3 !dout_oe && $past(dout_oe))
        else $error("accel release late");
    AST_TEMP_HOLD: assert property (
        $rose(temp_frame_select_n) && acc_frame_select_n |-> $stable(dout) [*3] ##1 !dout_oe)
        else $error("temp last bit not held");
    AST_DRIVE_WINDOW: assert property (
        dout_oe |-> !$past(acc_frame_select_n, 3) || !$past(temp_frame_select_n, 3))
        else $error("driving outside frame");
    AST_DOUT_FALL: assert property (
        dout_oe && $past(dout_oe) && $changed(dout) |-> !$past(sclk, 3))
        else $error("dout moved off falling edge");
    AST_AXIS_RISE: assert property (
        $changed(axis_y) |-> !acc_frame_select_n && $past(sclk, 3))
        else $error("axis changed off rising edge");
    AST_SHUT_SET: assert property (
        $rose(power_down) |-> !acc_frame_select_n && $past(sclk, 3))
        else $error("shutdown entered outside frame");
    AST_SHUT_CLEAR: assert property (
        $fell(power_down) |-> !acc_frame_select_n && $past(sclk, 3))
        else $error("wake outside rising edge");
    AST_TCTL_WRITE: assert property (
        $changed(temp_control) |-> !temp_frame_select_n && $past(sclk, 3))
        else $error("temp control written outside frame");

    COV_ACC: cover property ($fell(acc_frame_select_n));
    COV_TEMP: cover property ($fell(temp_frame_select_n));
    COV_SHUT: cover property ($fell(power_down));
endmodule
`default_nettype wire

// [tb/serial_master.sv]
// External serial master that frames transfers and samples data-out.
`timescale 1ns/1ps
`default_nettype none
module serial_master (
    input  wire logic clock,
    input  wire logic dout,
    output logic      acc_n,
    output logic      temp_n,
    output logic      sclk,
    output logic      din
);
    // Idle pins: selects high, clock standing low.
    initial
    begin
        acc_n = 1'b1;
        temp_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end

    // Runs n frames under one select; sclk period is eight system clocks.
    task automatic run(input bit tmp, input logic [7:0] c0, input logic [7:0] c1,
                       input int n, output logic [15:0] w0, output logic [15:0] w1);
        logic [15:0] w;
        @(posedge clock);
        if (tmp)
            temp_n <= 1'b0;
        else
            acc_n <= 1'b0;
        for (int f = 0; f < n; f++)
        begin
            for (int i = 15; i >= 0; i--)
            begin
                din <= (i > 7 && !tmp) ? (f > 0 ? c1[i-8] : c0[i-8]) : 1'b0;
                repeat (4) @(posedge clock);
                w = {w[14:0], dout};
                sclk <= 1'b1;
                repeat (4) @(posedge clock);
                sclk <= 1'b0;
            end
            if (f == 0)
                w0 = w;
            w1 = w;
        end
        repeat (4) @(posedge clock);
        acc_n <= 1'b1;
        temp_n <= 1'b1;
        din <= ~din; // Idle data shows the inverse so a stale bit cannot pass.
        // accelerometer frames spaced for at most 10 kSPS
        repeat (tmp ? 6 : 5000) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the accelerometer serial port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                    clock = 1'b0;
    logic                    rst_n = 1'b0;
    logic                    st = 1'b0;
    logic                    sv = 1'b0;
    logic [9:0]              tc = 10'h000;
    accel_port_pkg::sample_s sd = '0;
    accel_port_pkg::sample_s last = {2{accel_port_pkg::ACC_MIDPOINT}};
    accel_port_pkg::sample_s q[$];
    logic                    acc_n, temp_n, sclk, din, dout, dout_oe, sr, pd, ay;
    logic [7:0]              tctl;
    logic                    dout_seen;
    logic                    mpd = 1'b0;
    logic                    max = 1'b0;
    int                      n_fail = 0;
    int                      n_compared = 0;
    int                      cyc = 0;

    always #10 clock = ~clock;

    // A released data-out has no pull, so the master sees the inverse of the held bit.
    assign dout_seen = dout_oe ? dout : ~dout;

    serial_master m (.clock(clock), .dout(dout_seen), .acc_n(acc_n), .temp_n(temp_n),
                     .sclk(sclk), .din(din));

    accel_serial_port #(.FIFO_DEPTH(8)) dut (
        .clock(clock), .rst_n(rst_n), .acc_frame_select_n(acc_n),
        .temp_frame_select_n(temp_n), .sclk(sclk), .din(din), .dout(dout),
        .dout_oe(dout_oe), .selftest_in(st), .sample_valid(sv), .sample_ready(sr),
        .sample_data(sd), .temp_code(tc), .power_down(pd), .axis_y(ay),
        .temp_control(tctl));

    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // A hang cuts the run short as a failure.
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 70000)
        begin
            n_fail++;
            complete_run();
        end
    end

    // Offers one sample and holds it until the buffer takes it.
    task automatic push(input logic [11:0] x, input logic [11:0] y);
        @(posedge clock);
        sv <= 1'b1;
        sd <= {x, y};
        q.push_back({x, y});
        do @(posedge clock); while (sr !== 1'b1);
        sv <= 1'b0;
    endtask

    // Accelerometer frames; the model pops one sample per live capture.
    task automatic acc(input logic [7:0] c0, input logic [7:0] c1, input int n);
        logic [15:0] w[2];
        logic [11:0] e;
        m.run(1'b0, c0, c1, n, w[0], w[1]);
        for (int f = 0; f < n; f++)
        begin
            if (!mpd && q.size() > 0)
                last = q.pop_front();
            e = max ? last.y_code : last.x_code;
            e = mpd ? accel_port_pkg::ACC_SHUTDOWN : e + (st ? accel_port_pkg::SELFTEST_DELTA : 12'h000);
            chk("accel word", {4'h0, e}, w[f]);
            max = f > 0 ? c1[3] : c0[3];
            mpd = f > 0 ? c1[0] : c0[0];
        end
        chk("axis", {15'h0, max}, {15'h0, ay});
        chk("shutdown", {15'h0, mpd}, {15'h0, pd});
        chk("drive after frame", 16'h0, {15'h0, dout_oe});
    endtask

    // Temperature frame; data-in is held low throughout, and tctl is checked against c.
    task automatic temp(input logic [9:0] code, input logic [7:0] c);
        logic [15:0] w0, w1;
        tc <= code;
        m.run(1'b1, c, 8'h00, 1, w0, w1);
        chk("temp word", {1'b0, code, {5{code[0]}}}, w0);
        chk("temp first byte", {8'h00, 1'b0, code[9:3]}, {8'h00, w0[15:8]});
        chk("temp control", {8'h00, c}, {8'h00, tctl});
        chk("temp release", 16'h0, {15'h0, dout_oe});
    endtask

    task automatic s_reset();
        chk("reset pins", 16'h0100, {4'h0, dout_oe, pd, ay, sr, tctl});
        acc(8'h04, 8'h04, 1);
        acc(8'h84, 8'h84, 1);
    endtask

    task automatic s_fifo();
        for (int i = 0; i < 8; i++)
            push(accel_port_pkg::ACC_PLUS_5G + 12'(i), accel_port_pkg::ACC_MINUS_5G + 12'(i));
        repeat (2) @(posedge clock);
        chk("buffer full", 16'h0, {15'h0, sr});
        for (int k = 0; k < 4; k++)
            acc(8'h0c, 8'h04, 2);
        acc(8'h04, 8'h04, 1);
        chk("buffer drained", 16'h1, {15'h0, sr});
    endtask

    task automatic s_shut();
        acc(8'h0d, 8'h0d, 2);
        acc(8'h0c, 8'h0c, 1);
        acc(8'h04, 8'h04, 1);
    endtask

    task automatic s_misc();
        st <= 1'b1;
        acc(8'h04, 8'h04, 1);
        st <= 1'b0;
        temp(10'h190, 8'h00);
        temp(10'h360, 8'h00);
    endtask

    // Reset for ten cycles, then the scenarios in turn.
    initial
    begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        s_reset();
        s_fifo();
        s_shut();
        s_misc();
        complete_run();
    end
endmodule

bind accel_serial_port port_sva sva_i (.clock(clock), .rst_n(rst_n),
    .acc_frame_select_n(acc_frame_select_n), .temp_frame_select_n(temp_frame_select_n),
    .sclk(sclk), .dout(dout), .dout_oe(dout_oe), .power_down(power_down),
    .axis_y(axis_y), .temp_control(temp_control));
`default_nettype wire
